// ---- pkg/pwmet_map.vh ----
`ifndef PWMET_MAP_VH
`define PWMET_MAP_VH

`define PWMET_ADDR_W          12
`define PWMET_OFF_CMP         12'h000
`define PWMET_OFF_PIN         12'h004
`define PWMET_OFF_CON2        12'h008
`define PWMET_OFF_IRQ_STAT    12'h00C
`define PWMET_OFF_IRQ_MASK    12'h010
`define PWMET_OFF_TB_STAT     12'h014

`define PWMET_RST_CMP         16'h0000
`define PWMET_RST_PIN         16'h00FF
`define PWMET_RST_CON2        16'h0000
`define PWMET_RST_IRQ         2'h0

`define PWMET_CMP_DIR_BIT     15
`define PWMET_CMP_VAL_MSB     14
`define PWMET_TB_DIR_BIT      15
`define PWMET_PIN_MODE_MSB    11
`define PWMET_PIN_MODE_LSB    8
`define PWMET_PIN_HIGH_MSB    7
`define PWMET_PIN_HIGH_LSB    4
`define PWMET_PIN_LOW_MSB     3
`define PWMET_PIN_LOW_LSB     0
`define PWMET_PIN_WMASK       16'h0FFF
`define PWMET_CON2_PS_MSB     11
`define PWMET_CON2_PS_LSB     8
`define PWMET_CON2_WMASK      16'h0F07

`define PWMET_IRQ_TRIG_BIT    0
`define PWMET_IRQ_MATCH_BIT   1

`endif

// ---- design/pwmet_postscale.v ----
`timescale 1ns/1ps
module pwmet_postscale
(
   // Clock and reset.
   input  wire       clock,
   input  wire       rst,
   // Control.
   input  wire [3:0] select,
   input  wire       restart,
   // Events.
   input  wire       event_in,
   output reg        event_out
);

   reg [3:0] count;

   always @(posedge clock)
   begin
      if (rst)
      begin
         count     <= 4'h0;
         event_out <= 1'b0;
      end
      else if (restart)
      begin
         // A new ratio starts from a clean count so the first pass is exact.
         count     <= 4'h0;
         event_out <= 1'b0;
      end
      else if (event_in)
      begin
         if (count == select)
         begin
            count     <= 4'h0;
            event_out <= 1'b1;
         end
         else
         begin
            count     <= count + 4'h1;
            event_out <= 1'b0;
         end
      end
      else
      begin
         event_out <= 1'b0;
      end
   end

endmodule

// ---- design/pwmet_pin_mux.v ----
`timescale 1ns/1ps
module pwmet_pin_mux
(
   // Clock and reset.
   input  wire       clock,
   input  wire       rst,
   // Configuration.
   input  wire [3:0] pair_output_mode,
   input  wire [3:0] high_side_pin_enable,
   input  wire [3:0] low_side_pin_enable,
   // Duty generator signals.
   input  wire [3:0] duty_high,
   input  wire [3:0] duty_low,
   // Pins.
   output reg  [3:0] high_side_output,
   output reg  [3:0] high_side_oe,
   output reg  [3:0] low_side_output,
   output reg  [3:0] low_side_oe
);

   reg [3:0] next_low;
   integer   i;

   always @*
   begin
      next_low = 4'h0;
      for (i = 0; i < 4; i = i + 1)
      begin
         // Complementary mode drives the low pin as the inverse of duty_high; no dead time is inserted.
         next_low[i] = pair_output_mode[i] ? duty_low[i] : ~duty_high[i];
      end
   end

   always @(posedge clock)
   begin
      if (rst)
      begin
         high_side_output <= 4'h0;
         high_side_oe     <= 4'h0;
         low_side_output  <= 4'h0;
         low_side_oe      <= 4'h0;
      end
      else
      begin
         high_side_output <= duty_high & high_side_pin_enable;
         high_side_oe     <= high_side_pin_enable;
         low_side_output  <= next_low & low_side_pin_enable;
         low_side_oe      <= low_side_pin_enable;
      end
   end

endmodule

// ---- design/pwmet_top.v ----
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "pwmet_map.vh"
module pwmet_top
(
   // Clock and reset.
   input  wire        clock,
   input  wire        rst,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Time base and duty generators.
   input  wire [15:0] time_base_count,
   input  wire [3:0]  duty_high,
   input  wire [3:0]  duty_low,
   // Output pins.
   output wire [3:0]  high_side_output,
   output wire [3:0]  high_side_oe,
   output wire [3:0]  low_side_output,
   output wire [3:0]  low_side_oe,
   // Converter trigger and interrupt.
   output wire        adc_trigger,
   output reg         irq
);

   reg  [15:0] special_event_compare;
   reg  [15:0] pin_mode_and_enable_control;
   reg  [15:0] trigger_postscale_and_update_control;
   reg  [1:0]  irq_status;
   reg  [1:0]  irq_mask;
   reg         match_prev;
   reg  [31:0] next_rdata;
   reg         next_err;
   reg  [1:0]  next_status;
   reg  [15:0] next_compare;
   reg  [15:0] next_pin;
   reg  [15:0] next_con2;
   reg  [1:0]  next_mask;

   wire        access;
   wire        wr_en;
   wire        trigger_direction_select;
   wire [14:0] trigger_compare_value;
   wire        time_base_direction_flag;
   wire        match_now;
   wire        match_event;
   wire        post_event;
   wire        ps_restart;
   wire [3:0]  trigger_postscale_select;

   function is_mapped;
      input [11:0] addr;
      begin
         is_mapped = (addr == `PWMET_OFF_CMP)      ||
                     (addr == `PWMET_OFF_PIN)      ||
                     (addr == `PWMET_OFF_CON2)     ||
                     (addr == `PWMET_OFF_IRQ_STAT) ||
                     (addr == `PWMET_OFF_IRQ_MASK) ||
                     (addr == `PWMET_OFF_TB_STAT);
      end
   endfunction

   function [15:0] masked_write;
      input [15:0] old_value;
      input [15:0] new_value;
      input [15:0] mask;
      begin
         masked_write = (old_value & ~mask) | (new_value & mask);
      end
   endfunction

   function write_hit;
      input        strobe;
      input [11:0] addr;
      input [11:0] offset;
      begin
         write_hit = strobe && (addr == offset);
      end
   endfunction

   // Every transfer gets one wait state so read data comes from a flop.
   assign access = psel & penable & ~pready;
   assign wr_en  = psel & penable & pready & pwrite & ~pslverr;

   assign trigger_direction_select = special_event_compare[`PWMET_CMP_DIR_BIT];
   assign trigger_compare_value    = special_event_compare[`PWMET_CMP_VAL_MSB:0];
   assign time_base_direction_flag = time_base_count[`PWMET_TB_DIR_BIT];
   assign trigger_postscale_select =
      trigger_postscale_and_update_control[`PWMET_CON2_PS_MSB:`PWMET_CON2_PS_LSB];

   // A direction flag of one means counting down, so equal bits select the direction.
   assign match_now = (time_base_count[`PWMET_CMP_VAL_MSB:0] == trigger_compare_value)
                      && (time_base_direction_flag == trigger_direction_select);

   // The time base may dwell on one value for several clocks, so only the first counts.
   assign match_event = match_now & ~match_prev;

   assign ps_restart = write_hit(wr_en, paddr, `PWMET_OFF_CON2);

   always @(posedge clock)
   begin
      if (rst)
      begin
         match_prev <= 1'b0;
      end
      else
      begin
         match_prev <= match_now;
      end
   end

   pwmet_postscale u_postscale
   (
      .clock     (clock),
      .rst       (rst),
      .select    (trigger_postscale_select),
      .restart   (ps_restart),
      .event_in  (match_event),
      .event_out (post_event)
   );

   assign adc_trigger = post_event;

   pwmet_pin_mux u_pin_mux
   (
      .clock                (clock),
      .rst                  (rst),
      .pair_output_mode     (pin_mode_and_enable_control[`PWMET_PIN_MODE_MSB:`PWMET_PIN_MODE_LSB]),
      .high_side_pin_enable (pin_mode_and_enable_control[`PWMET_PIN_HIGH_MSB:`PWMET_PIN_HIGH_LSB]),
      .low_side_pin_enable  (pin_mode_and_enable_control[`PWMET_PIN_LOW_MSB:`PWMET_PIN_LOW_LSB]),
      .duty_high            (duty_high),
      .duty_low             (duty_low),
      .high_side_output     (high_side_output),
      .high_side_oe         (high_side_oe),
      .low_side_output      (low_side_output),
      .low_side_oe          (low_side_oe)
   );

   always @*
   begin
      next_rdata = 32'h00000000;
      next_err   = ~is_mapped(paddr);
      case (paddr)
         `PWMET_OFF_CMP:
         begin
            next_rdata[15:0] = special_event_compare;
         end
         `PWMET_OFF_PIN:
         begin
            next_rdata[15:0] = pin_mode_and_enable_control & `PWMET_PIN_WMASK;
         end
         `PWMET_OFF_CON2:
         begin
            next_rdata[15:0] = trigger_postscale_and_update_control & `PWMET_CON2_WMASK;
         end
         `PWMET_OFF_IRQ_STAT:
         begin
            next_rdata[1:0] = irq_status;
         end
         `PWMET_OFF_IRQ_MASK:
         begin
            next_rdata[1:0] = irq_mask;
         end
         `PWMET_OFF_TB_STAT:
         begin
            next_rdata[15:0] = time_base_count;
         end
         default:
         begin
            next_rdata = 32'h00000000;
         end
      endcase
   end

   always @(posedge clock)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready <= access;
         if (access)
         begin
            pslverr <= next_err;
            prdata  <= pwrite ? 32'h00000000 : next_rdata;
         end
         else
         begin
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
         end
      end
   end

   always @(posedge clock)
   begin
      if (rst)
      begin
         special_event_compare                <= `PWMET_RST_CMP;
         pin_mode_and_enable_control          <= `PWMET_RST_PIN;
         trigger_postscale_and_update_control <= `PWMET_RST_CON2;
         irq_mask                             <= `PWMET_RST_IRQ;
      end
      else
      begin
         special_event_compare                <= next_compare;
         pin_mode_and_enable_control          <= next_pin;
         trigger_postscale_and_update_control <= next_con2;
         irq_mask                             <= next_mask;
      end
   end

   // The new mask is used in the write cycle itself, so irq never lags a mask change.
   always @*
   begin
      next_compare = special_event_compare;
      next_pin     = pin_mode_and_enable_control;
      next_con2    = trigger_postscale_and_update_control;
      next_mask    = irq_mask;
      if (write_hit(wr_en, paddr, `PWMET_OFF_CMP))
      begin
         next_compare = pwdata[15:0];
      end
      if (write_hit(wr_en, paddr, `PWMET_OFF_PIN))
      begin
         next_pin = masked_write(pin_mode_and_enable_control,
                                 pwdata[15:0], `PWMET_PIN_WMASK);
      end
      if (write_hit(wr_en, paddr, `PWMET_OFF_CON2))
      begin
         // Unimplemented bits keep their zero reset value.
         next_con2 = masked_write(trigger_postscale_and_update_control,
                                  pwdata[15:0], `PWMET_CON2_WMASK);
      end
      if (write_hit(wr_en, paddr, `PWMET_OFF_IRQ_MASK))
      begin
         next_mask = pwdata[1:0];
      end
   end

   always @*
   begin
      next_status = irq_status;
      if (write_hit(wr_en, paddr, `PWMET_OFF_IRQ_STAT))
      begin
         next_status = irq_status & ~pwdata[1:0];
      end
      // A new event in the clearing cycle is kept.
      if (post_event)
      begin
         next_status[`PWMET_IRQ_TRIG_BIT] = 1'b1;
      end
      if (match_event)
      begin
         next_status[`PWMET_IRQ_MATCH_BIT] = 1'b1;
      end
   end

   always @(posedge clock)
   begin
      if (rst)
      begin
         irq_status <= `PWMET_RST_IRQ;
         irq        <= 1'b0;
      end
      else
      begin
         irq_status <= next_status;
         irq        <= |(next_status & next_mask);
      end
   end

endmodule

// ---- testbench/pwmet_checker_properties.sv ----
`timescale 1ns/1ps
`include "pwmet_map.vh"
module pwmet_checker
(
   // Clock and reset.
   input wire        clock,
   input wire        rst,
   // APB.
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Time base, pins, trigger.
   input wire [15:0] time_base_count,
   input wire [3:0]  duty_high,
   input wire [3:0]  duty_low,
   input wire [3:0]  high_side_output,
   input wire [3:0]  high_side_oe,
   input wire [3:0]  low_side_output,
   input wire [3:0]  low_side_oe,
   input wire        adc_trigger,
   input wire        irq
);
   // Shadows follow completed writes, so no view inside the design is needed.
   logic [15:0] cmp_sh;
   logic [3:0]  mode_sh;
   logic        mask_sh;
   wire         wr = psel && penable && pready && pwrite && !pslverr;
   wire  [3:0]  low_exp = (mode_sh & duty_low) | (~mode_sh & ~duty_high);
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cmp_sh <= 16'h0000;
         mode_sh <= 4'h0;
         mask_sh <= 1'b0;
      end
      else if (wr)
      begin
         if (paddr == `PWMET_OFF_CMP) cmp_sh <= pwdata[15:0];
         if (paddr == `PWMET_OFF_PIN) mode_sh <= pwdata[11:8];
         if (paddr == `PWMET_OFF_IRQ_MASK) mask_sh <= pwdata[0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_access;
      psel && penable && !pready;
   endsequence
   AST_APB_WAIT:
      assert property (s_access |=> pready) else $error("pready late");
   AST_READY_PULSE:
      assert property (pready |=> !pready) else $error("pready held");
   AST_ERR_WITH_READY:
      assert property (pslverr |-> pready) else $error("pslverr alone");
   AST_UPPER_ZERO:
      assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper data set");
   AST_TRIG_PULSE:
      assert property (adc_trigger |=> !adc_trigger) else $error("trigger held");
   AST_TRIG_MATCH:
      assert property (adc_trigger |-> $past(time_base_count) == $past(cmp_sh))
         else $error("trigger without match");
   AST_PIN_GPIO:
      assert property (((high_side_output & ~high_side_oe) | (low_side_output & ~low_side_oe))
         == 4'h0) else $error("disabled pin driven");
   AST_HIGH_FOLLOW:
      assert property ((high_side_output & high_side_oe) == ($past(duty_high) & high_side_oe))
         else $error("high pin wrong");
   AST_LOW_MODE:
      assert property ((low_side_output & low_side_oe) == ($past(low_exp) & low_side_oe))
         else $error("low pin wrong");
   AST_IRQ_TRIG:
      assert property (adc_trigger && mask_sh |-> ##[0:1] irq) else $error("irq missing");
endmodule
bind pwmet_top pwmet_checker i_chk
(
   .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .time_base_count(time_base_count), .duty_high(duty_high), .duty_low(duty_low),
   .high_side_output(high_side_output), .high_side_oe(high_side_oe),
   .low_side_output(low_side_output), .low_side_oe(low_side_oe),
   .adc_trigger(adc_trigger), .irq(irq)
);

// ---- testbench/pwmet_time_base.sv ----
`timescale 1ns/1ps
module pwmet_time_base #(parameter int PERIOD = 9)
(
   // Clock, reset and pacing.
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        run,
   input  wire logic        stall,
   // Count, direction in bit 15.
   output logic      [15:0] time_base_count
);
   // A stall holds the count, so one match may last several cycles.
   always_ff @(posedge clock)
   begin
      if (rst || !run)
         time_base_count <= 16'h0000;
      else if (!stall && time_base_count[15])
         time_base_count <= (time_base_count[14:0] == 15'h0001) ? 16'h0000
                            : time_base_count - 16'h0001;
      else if (!stall)
         time_base_count <= (time_base_count[14:0] == PERIOD - 1) ? {1'b1, 15'(PERIOD)}
                            : time_base_count + 16'h0001;
   end
endmodule

// ---- testbench/pwm_event_trigger_pin_config_bench.sv ----
`timescale 1ns/1ps
`include "pwmet_map.vh"
module pwm_event_trigger_pin_config_bench;
   logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, run = 1'b0, stall = 1'b0, prev_m = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, lfsr = 32'hB05F15AB, prdata;
   logic [15:0] cmp_m = 16'h0000, tbc;
   logic [3:0]  duty_high = 4'h0, duty_low = 4'h0, dh_prev = 4'h0, hso, hoe, lso, loe;
   logic        pready, pslverr, adc_trigger, irq;
   logic [4:0]  cases[5] = '{5'h00, 5'h11, 5'h03, 5'h1F, 5'h12};
   logic [32:0] rdq[$];
   int          trq[$];
   int          n_errors = 0, n_tests = 0, cyc = 0, nev = 0, sel = 0;
   pwmet_top i_dut
   (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .time_base_count(tbc), .duty_high(duty_high), .duty_low(duty_low),
      .high_side_output(hso), .high_side_oe(hoe), .low_side_output(lso),
      .low_side_oe(loe), .adc_trigger(adc_trigger), .irq(irq)
   );
   pwmet_time_base #(.PERIOD(9)) i_tb
   (
      .clock(clock), .rst(rst), .run(run), .stall(stall), .time_base_count(tbc)
   );
   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                      input logic [32:0] exp);
      int k;
      k = 0;
      rdq.push_back(exp);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k == 20)
      begin
         n_errors++;
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   initial
   begin
      forever #20 clock = ~clock;
   end
   always @(posedge clock)
   begin
      lfsr <= next_rand(lfsr);
      duty_high <= lfsr[3:0];
      duty_low <= lfsr[7:4];
      stall <= lfsr[8] & lfsr[9];
   end
   // Each pulse must land one cycle after the event that completes a group.
   always @(posedge clock)
   begin
      cyc++;
      if (pready === 1'b1) check("apb", rdq.pop_front(), {pslverr, prdata});
      if (!rst) check("high_pins", {29'h0, dh_prev & hoe}, {29'h0, hso});
      dh_prev = duty_high;
      if (adc_trigger === 1'b1) check("trig", trq.size() ? trq.pop_front() : 0, cyc);
      if (!rst && tbc === cmp_m && !prev_m && ++nev == sel + 1)
      begin
         nev = 0;
         trq.push_back(cyc + 1);
      end
      prev_m = !rst && tbc === cmp_m;
   end
   initial
   begin
      logic [15:0] v;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      apb(1'b0, `PWMET_OFF_CMP, 16'h0000, 33'h0);
      apb(1'b0, `PWMET_OFF_PIN, 16'h0000, 33'h0FF);
      apb(1'b1, `PWMET_OFF_CON2, 16'hFFFF, 33'h0);
      apb(1'b0, `PWMET_OFF_CON2, 16'h0000, 33'hF07);
      apb(1'b0, 12'h018, 16'h0000, 33'h100000000);
      repeat (4)
      begin
         v = lfsr[15:0];
         apb(1'b1, `PWMET_OFF_PIN, v, 33'h0);
         apb(1'b0, `PWMET_OFF_PIN, 16'h0000, {17'h0, v & 16'h0FFF});
         check("oe", {25'h0, v[7:0]}, {25'h0, hoe, loe});
      end
      foreach (cases[i])
      begin
         cmp_m = {cases[i][4], 15'h0005};
         apb(1'b1, `PWMET_OFF_CMP, cmp_m, 33'h0);
         apb(1'b1, `PWMET_OFF_IRQ_MASK, {15'h0, cases[i][4]}, 33'h0);
         apb(1'b0, `PWMET_OFF_IRQ_MASK, 16'h0000, {32'h0, cases[i][4]});
         apb(1'b1, `PWMET_OFF_IRQ_STAT, 16'h0003, 33'h0);
         apb(1'b1, `PWMET_OFF_CON2, {4'h0, cases[i][3:0], 8'h00}, 33'h0);
         sel = cases[i][3:0];
         nev = 0;
         run <= 1'b1;
         repeat (600) @(posedge clock);
         run <= 1'b0;
         repeat (3) @(posedge clock);
         check("irq", {32'h0, cases[i][4]}, {32'h0, irq});
         apb(1'b0, `PWMET_OFF_IRQ_STAT, 16'h0000, 33'h3);
         apb(1'b1, `PWMET_OFF_IRQ_STAT, 16'h0003, 33'h0);
         repeat (2) @(posedge clock);
         check("irq_clear", 33'h0, {32'h0, irq});
      end
      apb(1'b1, `PWMET_OFF_TB_STAT, 16'hFFFF, 33'h0);
      apb(1'b0, `PWMET_OFF_TB_STAT, 16'h0000, 33'h0);
      check("pending", 33'h0, {1'b0, 32'(trq.size())});
      complete_run();
   end
endmodule
